/* fsp_params.svh */
/*
 * constants of the flash security and self-program gate: register
 * offsets, field positions, reset values and timing counts.
 * assumes it is included by bare name from files that need it.
 */
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// register offsets on the plain register port
`define FSP_REG_CTRL 4'h0
`define FSP_REG_CMD 4'h1
`define FSP_REG_ADDR 4'h2
`define FSP_REG_DATA 4'h3
`define FSP_REG_STATUS 4'h4

// control register bits (write only, self clearing)
`define FSP_CTRL_ENTER 0
`define FSP_CTRL_LEAVE 1
`define FSP_CTRL_CLEAR 2

// security setting bit positions
`define FSP_SEC_CE 0
`define FSP_SEC_BE 1
`define FSP_SEC_WR 2
`define FSP_SEC_BOOT 3
`define FSP_SEC_RESET 4'h0

// status register bit positions
`define FSP_ST_SELF 0
`define FSP_ST_WAIT 1
`define FSP_ST_HALT 2
`define FSP_ST_DONE 3
`define FSP_ST_OK 4
`define FSP_ST_REFUSED 5
`define FSP_ST_PROG 6
`define FSP_ST_ACT_LO 8
`define FSP_ST_STO_LO 12

// last address of the protected boot region
`define FSP_BOOT_LAST 16'h0FFF

// timing: clock period and oscillator settling wait
`define FSP_CLK_PERIOD_PS 4000
`define FSP_HSO_WAIT_NS 2000
`define FSP_HSO_WAIT_CYC ((`FSP_HSO_WAIT_NS * 1000 + `FSP_CLK_PERIOD_PS - 1) / `FSP_CLK_PERIOD_PS)

// cycles after reset release before the mode pin is sampled
`define FSP_MODE_SETTLE 2'h2

`endif

/* fsp_pkg.sv */
/*
 * types of the flash security and self-program gate: command codes
 * and the self-programming state machine encoding.
 * assumes nothing; used by scoped name only.
 */
package fsp_pkg;

    // flash command codes, codes 4..7 are illegal
    typedef enum logic [2:0] {
        FSP_OP_CHIP_ERASE = 3'h0,
        FSP_OP_BLOCK_ERASE = 3'h1,
        FSP_OP_WRITE = 3'h2,
        FSP_OP_SET_SEC = 3'h3
    } fsp_op_t;

    // self-programming sequencer states
    typedef enum logic [1:0] {
        FSP_SP_OFF = 2'h0,
        FSP_SP_READY = 2'h1,
        FSP_SP_WAIT = 2'h2
    } fsp_sp_state_t;

endpackage : fsp_pkg

/* fsp_sync.sv */
/*
 * two flip-flop level synchroniser with clock enable.
 * assumes the input is asynchronous to clk_sys_i.
 */
`timescale 1ns/1ps
module fsp_sync (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_r; // first stage, read only by the second
    logic sync_r; // second stage

    // two stage capture
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else if (clk_en_i) begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule : fsp_sync

/* fsp_gate.sv */
/*
 * flash security and self-program gate: holds the four security
 * settings, accepts or refuses programmer and self-programming
 * commands, and sequences self-programming on the cpu side.
 * assumes a flash array that executes fl_req_o pulses, an interrupt
 * controller on the same clock, and a programmer command decoder.
 */
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_gate #(
    parameter logic [15:0] HSO_WAIT_CYC = 16'(`FSP_HSO_WAIT_CYC)
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    input wire logic clk_en_i,
    input wire logic program_mode_select_pin_i,
    input wire logic cpu_on_subclk_i,
    input wire logic cpu_on_main_osc_i,
    input wire logic [7:0] irq_request_flags_low0_i,
    input wire logic [7:0] irq_request_flags_high0_i,
    input wire logic [7:0] irq_request_flags_low1_i,
    input wire logic [7:0] irq_request_flags_high1_i,
    input wire logic [7:0] irq_mask_flags_low0_i,
    input wire logic [7:0] irq_mask_flags_high0_i,
    input wire logic [7:0] irq_mask_flags_low1_i,
    input wire logic [7:0] irq_mask_flags_high1_i,
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_op_i,
    input wire logic [15:0] cmd_addr_i,
    input wire logic [7:0] cmd_data_i,
    output logic rsp_valid_o,
    output logic rsp_ack_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic fl_req_o,
    output logic [2:0] fl_op_o,
    output logic [15:0] fl_addr_o,
    output logic [7:0] fl_data_o
);
    // decide whether a command may run against the given settings
    function automatic logic fsp_allowed(input logic [2:0] op,
            input logic [15:0] addr, input logic [3:0] sec,
            input logic self_m);
        logic boot_hit;
        logic lock;
        logic ok;
        boot_hit = sec[`FSP_SEC_BOOT] && (addr <= `FSP_BOOT_LAST);
        lock = !self_m;
        ok = 1'b0;
        if (op == fsp_pkg::FSP_OP_CHIP_ERASE) begin
            // whole array includes boot region
            ok = !sec[`FSP_SEC_BOOT]
                && !(lock && sec[`FSP_SEC_CE]);
        end else if (op == fsp_pkg::FSP_OP_BLOCK_ERASE) begin
            ok = !boot_hit && !(lock && (sec[`FSP_SEC_CE]
                || sec[`FSP_SEC_BE] || sec[`FSP_SEC_WR]));
        end else if (op == fsp_pkg::FSP_OP_WRITE) begin
            // chip-erase disable does not stop writes
            ok = !boot_hit && !(lock && sec[`FSP_SEC_WR]);
        end else if (op == fsp_pkg::FSP_OP_SET_SEC) begin
            ok = 1'b1;
        end
        return ok;
    endfunction : fsp_allowed

    logic pin_s; // synchronised mode pin
    logic [1:0] settle_r, settle_nxt; // cycles since reset release
    logic mode_done_r, mode_done_nxt; // mode has been sampled
    logic prog_mode_r, prog_mode_nxt; // programmer mode selected
    logic [3:0] sec_sto_r, sec_sto_nxt; // settings as last programmed
    logic [3:0] sec_act_r, sec_act_nxt; // settings enforced this session
    logic rsp_valid_r, rsp_valid_nxt;
    logic rsp_ack_r, rsp_ack_nxt;
    logic fl_req_r, fl_req_nxt;
    logic [2:0] fl_op_r, fl_op_nxt;
    logic [15:0] fl_addr_r, fl_addr_nxt;
    logic [7:0] fl_data_r, fl_data_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    fsp_pkg::fsp_sp_state_t sp_r, sp_nxt; // self-programming state
    logic [15:0] wait_r, wait_nxt; // oscillator settling count
    logic [2:0] sp_op_r, sp_op_nxt; // pending self command
    logic [15:0] sp_addr_r, sp_addr_nxt; // self address register
    logic [7:0] sp_data_r, sp_data_nxt; // self data register
    logic halt_r, halt_nxt; // sticky: halted by interrupt
    logic done_r, done_nxt; // sticky: self command finished
    logic ok_r, ok_nxt; // result of last self command
    logic refused_r, refused_nxt; // sticky: entry refused
    logic irq_pend; // any unmasked request pending
    logic iss_v; // a command is presented this cycle
    logic iss_self; // it comes from the self path
    logic [2:0] iss_op;
    logic [15:0] iss_addr;
    logic [7:0] iss_data;
    logic iss_ok; // the settings allow it
    logic sp_fire; // self command executes this cycle
    logic cmd_pend_r; // self command waiting one cycle to fire
    logic wr_ctrl, wr_cmd; // register write decodes
    logic clr_flags; // software clears sticky flags

    // mode pin comes from outside, two flops first
    fsp_sync u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .async_i(program_mode_select_pin_i),
        .sync_o(pin_s)
    );

    // requests not masked stop self mode whatever the global enable
    assign irq_pend = |((irq_request_flags_low0_i & ~irq_mask_flags_low0_i)
        | (irq_request_flags_high0_i & ~irq_mask_flags_high0_i)
        | (irq_request_flags_low1_i & ~irq_mask_flags_low1_i)
        | (irq_request_flags_high1_i & ~irq_mask_flags_high1_i));

    assign wr_ctrl = reg_wr_i && (reg_addr_i == `FSP_REG_CTRL);
    assign wr_cmd = reg_wr_i && (reg_addr_i == `FSP_REG_CMD);
    assign clr_flags = wr_ctrl && reg_wdata_i[`FSP_CTRL_CLEAR];

    // a presented command: programmer strobe or self fire
    assign iss_v = prog_mode_r ? (cmd_valid_i && mode_done_r) : sp_fire;

    // command source mux: programmer in prog mode, else self path
    always_comb begin
        iss_self = !prog_mode_r;
        iss_op = prog_mode_r ? cmd_op_i : sp_op_r;
        iss_addr = prog_mode_r ? cmd_addr_i : sp_addr_r;
        iss_data = prog_mode_r ? cmd_data_i : sp_data_r;
        iss_ok = fsp_allowed(iss_op, iss_addr, sec_act_r, iss_self);
    end

    // mode sampling and security settings, next values
    always_comb begin
        settle_nxt = settle_r;
        mode_done_nxt = mode_done_r;
        prog_mode_nxt = prog_mode_r;
        sec_act_nxt = sec_act_r;
        sec_sto_nxt = sec_sto_r;
        if (!mode_done_r) begin
            if (settle_r == `FSP_MODE_SETTLE) begin
                // pin level after reset release picks the mode
                mode_done_nxt = 1'b1;
                prog_mode_nxt = pin_s;
                sec_act_nxt = sec_sto_r;
            end else begin
                settle_nxt = settle_r + 2'h1;
            end
        end
        if (iss_v && iss_ok) begin
            if (iss_op == fsp_pkg::FSP_OP_SET_SEC) begin
                if (iss_self) begin
                    // self mode may only add boot protection
                    sec_sto_nxt[`FSP_SEC_BOOT] = sec_sto_r[`FSP_SEC_BOOT]
                        | iss_data[`FSP_SEC_BOOT];
                end else begin
                    // any combination, settings only ever added here
                    sec_sto_nxt = sec_sto_r | iss_data[3:0];
                end
            end else if (iss_op == fsp_pkg::FSP_OP_CHIP_ERASE && !iss_self
                    && !sec_sto_r[`FSP_SEC_CE]) begin
                // chip erase releases block-erase and write disables
                sec_sto_nxt[`FSP_SEC_BE] = 1'b0;
                sec_sto_nxt[`FSP_SEC_WR] = 1'b0;
            end
        end
    end

    // mode and security registers; stored settings survive rst_n_i
    always_ff @(posedge clk_sys_i) begin
        if (!por_n_i) begin
            sec_sto_r <= `FSP_SEC_RESET;
        end else if (clk_en_i) begin
            sec_sto_r <= sec_sto_nxt;
        end
        if (!rst_n_i) begin
            settle_r <= 2'h0;
            mode_done_r <= 1'b0;
            prog_mode_r <= 1'b0;
            sec_act_r <= `FSP_SEC_RESET;
        end else if (clk_en_i) begin
            settle_r <= settle_nxt;
            mode_done_r <= mode_done_nxt;
            prog_mode_r <= prog_mode_nxt;
            sec_act_r <= sec_act_nxt;
        end
    end

    // programmer answer and flash request, next values
    always_comb begin
        rsp_valid_nxt = cmd_valid_i;
        // illegal codes, wrong mode or refusal all answer nak
        rsp_ack_nxt = cmd_valid_i && prog_mode_r && mode_done_r
            && iss_ok;
        fl_req_nxt = 1'b0;
        fl_op_nxt = fl_op_r;
        fl_addr_nxt = fl_addr_r;
        fl_data_nxt = fl_data_r;
        if (iss_v && iss_ok && iss_op != fsp_pkg::FSP_OP_SET_SEC) begin
            // a refused command never reaches the array
            fl_req_nxt = 1'b1;
            fl_op_nxt = iss_op;
            fl_addr_nxt = iss_addr;
            fl_data_nxt = iss_data;
        end
    end

    // programmer answer and flash request registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rsp_valid_r <= 1'b0;
            rsp_ack_r <= 1'b0;
            fl_req_r <= 1'b0;
            fl_op_r <= 3'h0;
            fl_addr_r <= 16'h0000;
            fl_data_r <= 8'h00;
        end else if (clk_en_i) begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_ack_r <= rsp_ack_nxt;
            fl_req_r <= fl_req_nxt;
            fl_op_r <= fl_op_nxt;
            fl_addr_r <= fl_addr_nxt;
            fl_data_r <= fl_data_nxt;
        end
    end

    // self-programming sequencer, next values
    always_comb begin
        sp_nxt = sp_r;
        wait_nxt = wait_r;
        sp_op_nxt = sp_op_r;
        sp_addr_nxt = sp_addr_r;
        sp_data_nxt = sp_data_r;
        halt_nxt = halt_r && !clr_flags;
        done_nxt = done_r && !clr_flags;
        refused_nxt = refused_r && !clr_flags;
        ok_nxt = ok_r;
        sp_fire = 1'b0;
        if (reg_wr_i && reg_addr_i == `FSP_REG_ADDR) begin
            sp_addr_nxt = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == `FSP_REG_DATA) begin
            sp_data_nxt = reg_wdata_i[7:0];
        end
        unique case (sp_r)
            fsp_pkg::FSP_SP_OFF: begin
                if (wr_ctrl && reg_wdata_i[`FSP_CTRL_ENTER]) begin
                    // no entry on subclock, in prog mode or with pin low
                    if (cpu_on_subclk_i || prog_mode_r || !mode_done_r
                            || !pin_s) begin
                        refused_nxt = 1'b1;
                    end else begin
                        sp_nxt = fsp_pkg::FSP_SP_READY;
                    end
                end
            end
            fsp_pkg::FSP_SP_READY: begin
                if (wr_ctrl && reg_wdata_i[`FSP_CTRL_LEAVE]) begin
                    sp_nxt = fsp_pkg::FSP_SP_OFF;
                end else if (wr_cmd) begin
                    sp_op_nxt = reg_wdata_i[2:0];
                    if (cpu_on_main_osc_i) begin
                        // fast oscillator must settle first
                        sp_nxt = fsp_pkg::FSP_SP_WAIT;
                        wait_nxt = HSO_WAIT_CYC - 16'h0001;
                    end
                end
            end
            fsp_pkg::FSP_SP_WAIT: begin
                if (wait_r == 16'h0000) begin
                    sp_fire = 1'b1;
                    sp_nxt = fsp_pkg::FSP_SP_READY;
                end else begin
                    wait_nxt = wait_r - 16'h0001;
                end
            end
            default: begin
                sp_nxt = fsp_pkg::FSP_SP_OFF;
            end
        endcase
        // on internal oscillator a command runs the cycle after its write
        if (sp_r == fsp_pkg::FSP_SP_READY && wr_cmd && !cpu_on_main_osc_i
                && !(wr_ctrl && reg_wdata_i[`FSP_CTRL_LEAVE])) begin
            sp_op_nxt = reg_wdata_i[2:0];
        end
        if (sp_r == fsp_pkg::FSP_SP_READY && sp_op_r[2] == 1'b0
                && cmd_pend_r) begin
            sp_fire = 1'b1;
        end
        if (sp_fire) begin
            done_nxt = 1'b1;
            ok_nxt = iss_ok && !sp_op_r[2];
        end
        // pending request or dropped pin ends self mode at once
        if (sp_r != fsp_pkg::FSP_SP_OFF && (irq_pend || !pin_s)) begin
            sp_nxt = fsp_pkg::FSP_SP_OFF;
            sp_fire = 1'b0;
            done_nxt = done_r && !clr_flags;
            ok_nxt = ok_r;
            halt_nxt = halt_r || irq_pend; // set wins over clear
        end
    end

    // a command written on the internal oscillator fires next cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cmd_pend_r <= 1'b0;
        end else if (clk_en_i) begin
            cmd_pend_r <= (sp_r == fsp_pkg::FSP_SP_READY) && wr_cmd
                && !cpu_on_main_osc_i
                && !(wr_ctrl && reg_wdata_i[`FSP_CTRL_LEAVE]);
        end
    end

    // self-programming registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sp_r <= fsp_pkg::FSP_SP_OFF;
            wait_r <= 16'h0000;
            sp_op_r <= 3'h0;
            sp_addr_r <= 16'h0000;
            sp_data_r <= 8'h00;
            halt_r <= 1'b0;
            done_r <= 1'b0;
            ok_r <= 1'b0;
            refused_r <= 1'b0;
        end else if (clk_en_i) begin
            sp_r <= sp_nxt;
            wait_r <= wait_nxt;
            sp_op_r <= sp_op_nxt;
            sp_addr_r <= sp_addr_nxt;
            sp_data_r <= sp_data_nxt;
            halt_r <= halt_nxt;
            done_r <= done_nxt;
            ok_r <= ok_nxt;
            refused_r <= refused_nxt;
        end
    end

    // read data, valid only the cycle after the read strobe
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `FSP_REG_ADDR: rdata_nxt = sp_addr_r;
                `FSP_REG_DATA: rdata_nxt = {8'h00, sp_data_r};
                `FSP_REG_CMD: rdata_nxt = {13'h0000, sp_op_r};
                `FSP_REG_STATUS: begin
                    rdata_nxt[`FSP_ST_SELF] = sp_r != fsp_pkg::FSP_SP_OFF;
                    rdata_nxt[`FSP_ST_WAIT] = sp_r == fsp_pkg::FSP_SP_WAIT;
                    rdata_nxt[`FSP_ST_HALT] = halt_r;
                    rdata_nxt[`FSP_ST_DONE] = done_r;
                    rdata_nxt[`FSP_ST_OK] = ok_r;
                    rdata_nxt[`FSP_ST_REFUSED] = refused_r;
                    rdata_nxt[`FSP_ST_PROG] = prog_mode_r;
                    rdata_nxt[`FSP_ST_ACT_LO +: 4] = sec_act_r;
                    rdata_nxt[`FSP_ST_STO_LO +: 4] = sec_sto_r;
                end
                default: rdata_nxt = 16'h0000; // ctrl and unmapped
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_r <= 16'h0000;
        end else if (clk_en_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rsp_valid_o = rsp_valid_r;
    assign rsp_ack_o = rsp_ack_r;
    assign fl_req_o = fl_req_r;
    assign fl_op_o = fl_op_r;
    assign fl_addr_o = fl_addr_r;
    assign fl_data_o = fl_data_r;
    assign reg_rdata_o = rdata_r;

    // checks run only on enabled edges outside reset
    default clocking cb @(posedge clk_sys_i iff clk_en_i);
    endclocking
    default disable iff (!rst_n_i || !por_n_i);

    a_ce_blocks_erase: assert property (
        cmd_valid_i && prog_mode_r && sec_act_r[`FSP_SEC_CE]
        && cmd_op_i inside {3'h0, 3'h1} |=> !rsp_ack_o && !fl_req_o)
        else $error("erase taken under chip-erase disable");
    a_be_blocks_erase: assert property (
        cmd_valid_i && prog_mode_r && sec_act_r[`FSP_SEC_BE]
        && cmd_op_i == 3'h1 |=> rsp_valid_o && !rsp_ack_o)
        else $error("block erase taken under block-erase disable");
    a_wr_blocks_write: assert property (
        cmd_valid_i && prog_mode_r && sec_act_r[`FSP_SEC_WR]
        && cmd_op_i == 3'h2 |=> !fl_req_o && !rsp_ack_o)
        else $error("write taken under write disable");
    a_boot_guard: assert property (
        fl_req_o |-> !(sec_act_r[`FSP_SEC_BOOT] && (fl_op_o == 3'h0
        || fl_addr_o <= `FSP_BOOT_LAST)))
        else $error("boot region modified under protection");
    a_active_held: assert property (
        mode_done_r && $past(mode_done_r) |-> $stable(sec_act_r))
        else $error("active settings changed inside session");
    a_ce_permanent: assert property (
        sec_sto_r[`FSP_SEC_CE] |=> (sec_sto_r & $past(sec_sto_r))
        == $past(sec_sto_r))
        else $error("setting cleared after chip-erase disable");
    a_illegal_nak: assert property (
        cmd_valid_i && cmd_op_i[2] |=> rsp_valid_o && !rsp_ack_o)
        else $error("illegal command acknowledged");
    a_irq_halt: assert property (
        sp_r != fsp_pkg::FSP_SP_OFF && irq_pend
        |=> sp_r == fsp_pkg::FSP_SP_OFF && halt_r && !fl_req_o)
        else $error("self mode kept running with request pending");
    a_subclk_entry: assert property (
        $past(sp_r) == fsp_pkg::FSP_SP_OFF && sp_r != fsp_pkg::FSP_SP_OFF
        |-> !$past(cpu_on_subclk_i))
        else $error("self mode entered on subsystem clock");

    c_prog_write_ack: cover property (
        cmd_valid_i && cmd_op_i == 3'h2 ##1 rsp_ack_o);
    c_self_fire: cover property (sp_fire && iss_ok);
    c_osc_wait_done: cover property (
        sp_r == fsp_pkg::FSP_SP_WAIT ##1 sp_r == fsp_pkg::FSP_SP_READY);
    c_irq_halt: cover property (
        sp_r == fsp_pkg::FSP_SP_READY ##1 halt_r);
endmodule : fsp_gate

/* fsp_prog_model.sv */
/* programmer model: sends one command at a time on the command port.
   assumes the gate samples the strobe on the rising clock edge. */
`timescale 1ns/1ps
module fsp_prog_model (
    input wire logic clk_sys_i,
    output logic cmd_valid_o,
    output logic [2:0] cmd_op_o,
    output logic [15:0] cmd_addr_o,
    output logic [7:0] cmd_data_o
);
    // idle port at time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_op_o = 3'h0;
        cmd_addr_o = 16'h0;
        cmd_data_o = 8'h0;
    end
    // one-cycle strobe; address and data flip once no longer qualified
    task automatic send(input logic [2:0] op, input logic [15:0] a,
            input logic [7:0] d);
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b1;
        cmd_op_o <= op;
        cmd_addr_o <= a;
        cmd_data_o <= d;
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b0;
        cmd_addr_o <= ~a;
        cmd_data_o <= ~d;
    endtask : send
endmodule : fsp_prog_model

/* tb.sv */
/* self-checking bench of the flash security gate.
   assumes the programmer model file is compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
 $display("mismatch %0t value", $time); end end
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic por_n_i = 1'b0;
    logic pin = 1'b0; // mode select pin level
    logic subclk = 1'b0;
    logic mainosc = 1'b0;
    logic [31:0] irq_req = 32'h0; // no requests raised at entry
    logic [31:0] irq_msk = 32'hFFFFFFFF;
    logic [3:0] ra = 4'h0;
    logic [15:0] wd = 16'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cv, rv, ack, flq;
    logic [2:0] cop, flop;
    logic [15:0] cad, rdat, fla, st;
    logic [7:0] cdt, fld;
    int bad_count = 0;
    int check_count = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    fsp_prog_model u_prog (.clk_sys_i(clk_sys_i), .cmd_valid_o(cv),
        .cmd_op_o(cop), .cmd_addr_o(cad), .cmd_data_o(cdt));
    fsp_gate #(.HSO_WAIT_CYC(16'h4)) u_dut (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .por_n_i(por_n_i), .clk_en_i(1'b1),
        .program_mode_select_pin_i(pin), .cpu_on_subclk_i(subclk),
        .cpu_on_main_osc_i(mainosc),
        .irq_request_flags_low0_i(irq_req[7:0]),
        .irq_request_flags_high0_i(irq_req[15:8]),
        .irq_request_flags_low1_i(irq_req[23:16]),
        .irq_request_flags_high1_i(irq_req[31:24]),
        .irq_mask_flags_low0_i(irq_msk[7:0]),
        .irq_mask_flags_high0_i(irq_msk[15:8]),
        .irq_mask_flags_low1_i(irq_msk[23:16]),
        .irq_mask_flags_high1_i(irq_msk[31:24]),
        .cmd_valid_i(cv), .cmd_op_i(cop), .cmd_addr_i(cad), .cmd_data_i(cdt),
        .rsp_valid_o(rv), .rsp_ack_o(ack), .reg_addr_i(ra),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .fl_req_o(flq), .fl_op_o(flop), .fl_addr_o(fla), .fl_data_o(fld));
    // verdict and end of run
    task automatic end_sim;
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    // reset with mode pin level p, optional clear of stored settings
    task automatic boot(input logic p, input logic clr);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        por_n_i <= ~clr;
        pin <= p;
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        por_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
    endtask : boot
    // one command, answer and flash request judged
    task automatic cmd(input logic [2:0] op, input logic [15:0] a,
            input logic [7:0] d, input logic e);
        u_prog.send(op, a, d);
        #1 `CHK(rv, 1'b1)
        `CHK(ack, e)
        `CHK(flq, e & (op != 3'h3))
    endtask : cmd
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wreg
    task automatic rstat;
        @(posedge clk_sys_i);
        ra <= 4'h4;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 st = rdat;
    endtask : rstat
    // programmer session scenarios
    task automatic t_prog;
        boot(1'b1, 1'b1);
        rstat;
        `CHK(st[15:6], 10'h1)
        cmd(3'h2, 16'h2000, 8'h5A, 1'b1);
        cmd(3'h5, 16'h2000, 8'h00, 1'b0);
        cmd(3'h3, 16'h0, 8'h02, 1'b1);
        cmd(3'h1, 16'h2000, 8'h00, 1'b1);
        boot(1'b1, 1'b0);
        cmd(3'h1, 16'h2000, 8'h00, 1'b0);
        cmd(3'h3, 16'h0, 8'h04, 1'b1);
        boot(1'b1, 1'b0);
        cmd(3'h2, 16'h2000, 8'h11, 1'b0);
        cmd(3'h0, 16'h0, 8'h00, 1'b1);
        rstat;
        `CHK(st[15:12], 4'h0)
        cmd(3'h3, 16'h0, 8'h08, 1'b1);
        boot(1'b1, 1'b0);
        cmd(3'h2, 16'h0FFF, 8'h22, 1'b0);
        cmd(3'h2, 16'h1000, 8'h22, 1'b1);
        cmd(3'h0, 16'h0, 8'h00, 1'b0);
        boot(1'b1, 1'b1);
        cmd(3'h3, 16'h0, 8'h03, 1'b1);
        cmd(3'h0, 16'h0, 8'h00, 1'b1);
        boot(1'b1, 1'b0);
        cmd(3'h0, 16'h0, 8'h00, 1'b0);
        cmd(3'h1, 16'h4000, 8'h00, 1'b0);
        cmd(3'h2, 16'h4000, 8'h33, 1'b1);
        rstat;
        `CHK(st[15:12], 4'h3)
    endtask : t_prog
    // self-programming with chip-erase disable still stored
    task automatic t_self;
        boot(1'b0, 1'b0);
        cmd(3'h2, 16'h2000, 8'h44, 1'b0);
        pin <= 1'b1;
        subclk <= 1'b1;
        // let the pin pass its synchroniser so only the clock refuses
        repeat (2) @(posedge clk_sys_i);
        wreg(4'h0, 16'h0001);
        rstat;
        `CHK(st[5], 1'b1)
        subclk <= 1'b0;
        wreg(4'h2, 16'h2000);
        wreg(4'h3, 16'h005A);
        wreg(4'h0, 16'h0001);
        // block erase, refused by the programmer under these settings
        wreg(4'h1, 16'h0001);
        @(posedge clk_sys_i);
        #1 `CHK({flq, flop, fla, fld}, {1'b1, 3'h1, 16'h2000, 8'h5A})
        irq_req <= 32'h00010000;
        repeat (3) @(posedge clk_sys_i);
        rstat;
        `CHK(st[2:0], 3'h1)
        irq_msk <= 32'hFFFEFFFF;
        rstat;
        `CHK(st[2:0], 3'h4)
        irq_req <= 32'h0;
        wreg(4'h0, 16'h0001);
        mainosc <= 1'b1;
        wreg(4'h1, 16'h0002);
        rstat;
        `CHK(st[1:0], 2'h3)
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK(flq, 1'b1)
        rstat;
        `CHK(st[1:0], 2'h1)
        // dropping the pin ends the session
        pin <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rstat;
        `CHK(st[0], 1'b0)
    endtask : t_self
    initial begin
        t_prog;
        t_self;
        end_sim;
    end
    // watchdog
    initial begin
        #40000;
        bad_count++;
        end_sim;
    end
endmodule : tb
